// File: testbench/drt_pin_model.sv
// Pin-side partner: interrupt pin and counter pin off the clock grid
`timescale 1ns/1ps
module drt_pin_model (
   input  wire logic ext_level,
   input  wire logic io_pulse,
   output logic      ext_int_pin,
   output logic      timer_io_pin_in
);
   initial begin
      ext_int_pin     = 1'b0;
      timer_io_pin_in = 1'b1;
   end
   // Offset keeps edges unrelated to the clock phase
   always @(ext_level) ext_int_pin <= #2.3 ext_level;
   // Pull-up idle; one low pulse is one falling edge
   always @(posedge io_pulse) begin
      timer_io_pin_in = 1'b0;
      #17;
      timer_io_pin_in = 1'b1;
   end
endmodule : drt_pin_model

// File: testbench/drt_timer_properties.sv
// Concurrent checks on the dual reload timer ports
`timescale 1ns/1ps
module drt_timer_properties (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic [3:0] timer_control_second,
   input wire logic [3:0] timer_control_pin_select,
   input wire logic [2:0] ext_pin_control,
   input wire logic       skip_on_first_flag_instr,
   input wire logic       skip_on_second_flag_instr,
   input wire logic       second_int_taken,
   input wire logic       first_timer_underflow_flag,
   input wire logic       second_timer_underflow_flag,
   input wire logic       first_int_request,
   input wire logic       second_int_request,
   input wire logic       skip_next,
   input wire logic       sync_start_latched,
   input wire logic       timer_io_pin_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic skip_hit_any;
   // Either skip instruction meeting its set flag
   assign skip_hit_any = (skip_on_first_flag_instr && first_timer_underflow_flag)
                         || (skip_on_second_flag_instr && second_timer_underflow_flag);
   sequence s_skip_hit;
      skip_on_second_flag_instr && second_timer_underflow_flag;
   endsequence
   a_skip_on_flag: assert property (s_skip_hit |=> skip_next)
      else $error("no skip after set flag");
   a_skip_cause: assert property (skip_next |-> $past(skip_hit_any))
      else $error("skip without set flag");
   a_flag_clear_cause: assert property ($fell(second_timer_underflow_flag) |->
      $past(reset) || $past(skip_on_second_flag_instr || second_int_taken))
      else $error("flag cleared without cause");
   a_int_needs_flag: assert property (!(first_int_request && !first_timer_underflow_flag
      || second_int_request && !second_timer_underflow_flag))
      else $error("request without flag");
   a_oe_select: assert property (!reset |=>
      timer_io_pin_oe_n == !$past(timer_control_pin_select[0]))
      else $error("pin enable wrong");
   a_latch_enable: assert property (!$past(ext_pin_control[0]) |-> !sync_start_latched)
      else $error("latch set while disabled");
   a_latch_holds: assert property (sync_start_latched && ext_pin_control[0]
      && !timer_control_second[2] |=> sync_start_latched)
      else $error("latch dropped");
   a_auto_stop_cause: assert property ($fell(sync_start_latched) |-> $past(reset)
      || !$past(ext_pin_control[0]) || first_timer_underflow_flag)
      else $error("latch cleared without cause");
   a_reset_clear: assert property (disable iff (1'b0) reset |=> !skip_next
      && !sync_start_latched && timer_io_pin_oe_n)
      else $error("reset values wrong");
endmodule : drt_timer_properties
bind drt_timer_top drt_timer_properties chk (
   .core_clk                    (core_clk),
   .reset                       (reset),
   .timer_control_second        (timer_control_second),
   .timer_control_pin_select    (timer_control_pin_select),
   .ext_pin_control             (ext_pin_control),
   .skip_on_first_flag_instr    (skip_on_first_flag_instr),
   .skip_on_second_flag_instr   (skip_on_second_flag_instr),
   .second_int_taken            (second_int_taken),
   .first_timer_underflow_flag  (first_timer_underflow_flag),
   .second_timer_underflow_flag (second_timer_underflow_flag),
   .first_int_request           (first_int_request),
   .second_int_request          (second_int_request),
   .skip_next                   (skip_next),
   .sync_start_latched          (sync_start_latched),
   .timer_io_pin_oe_n           (timer_io_pin_oe_n)
);

// File: testbench/testbench.sv
// Self-checking bench for the dual reload timer
`timescale 1ns/1ps
module testbench;
   logic       core_clk = 1'b0, reset = 1'b1;
   logic [3:0] tc1 = 4'h0, tc2 = 4'h0, tps = 4'h0;
   logic [2:0] ext = 3'h0;
   logic [1:0] icf = 2'h0;
   logic       ld1 = 1'b0, ld2 = 1'b0, sk1 = 1'b0, sk2 = 1'b0, ext_level = 1'b0, io_pulse = 1'b0;
   logic       wr1 = 1'b0, it1 = 1'b0, it2 = 1'b0;
   logic [7:0] ldata = 8'h00, c1, c2;
   logic       pin_a, pin_b, f1, f2, ir1, ir2, skn, latch, pout, oe_n;
   int         n_mismatch = 0, comparisons = 0, seed = 32'ha412fe84, n, exp_c, k, exp_po;
   always #2.5 core_clk = ~core_clk;
   drt_pin_model pins (.ext_level(ext_level), .io_pulse(io_pulse), .ext_int_pin(pin_a),
                       .timer_io_pin_in(pin_b));
   drt_timer_top dut (.core_clk(core_clk), .reset(reset), .timer_control_first(tc1),
      .timer_control_second(tc2), .timer_control_pin_select(tps), .ext_pin_control(ext),
      .interrupt_control_first(icf), .load_first_timer_instr(ld1),
      .load_second_timer_instr(ld2), .write_first_reload_instr(wr1), .load_data(ldata),
      .skip_on_first_flag_instr(sk1), .skip_on_second_flag_instr(sk2),
      .first_int_taken(it1), .second_int_taken(it2), .ext_int_pin(pin_a),
      .timer_io_pin_in(pin_b), .first_count(c1), .second_count(c2),
      .first_timer_underflow_flag(f1), .second_timer_underflow_flag(f2),
      .first_int_request(ir1), .second_int_request(ir2), .skip_next(skn),
      .sync_start_latched(latch), .timer_io_pin_out(pout), .timer_io_pin_oe_n(oe_n));
   task automatic end_of_test();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int cycles);
      repeat (cycles) @(posedge core_clk);
      #1;
   endtask : step
   task automatic wait_for(ref logic sig, input logic val, input int bound);
      int i;
      i = 0;
      while (sig !== val && i < bound) begin
         step(1);
         i++;
      end
      check(sig, val);
      if (sig !== val) end_of_test();
   endtask : wait_for
   initial begin
      step(4);
      reset = 1'b0;
      step(1);
      check({f1, f2, skn, latch, oe_n, pout}, 8'h02);
      // Every-clock source on the second timer; model runs beside it
      n = $random(seed) & 7;
      ldata = n[7:0];
      ld2 = 1'b1;
      step(1);
      ld2 = 1'b0;
      tc2 = 4'hB;
      tps = 4'h3;
      icf = 2'b10;
      step(3);
      k = 0;
      while (c2 !== 8'h00 && k < 40) begin
         step(1);
         k++;
      end
      check(c2, 8'h00);
      if (c2 !== 8'h00) begin
         end_of_test();
      end
      exp_c = n;
      // Only a load of 1 has one reload before the first zero
      exp_po = (n == 1);
      repeat (20) begin
         step(1);
         if (exp_c == n) begin
            exp_po = 1 - exp_po;
         end
         check(c2, exp_c[7:0]);
         check(pout, exp_po[0]);
         exp_c = (exp_c == 0) ? n : exp_c - 1;
      end
      check({f2, ir2, oe_n}, 8'h06);
      tc2 = 4'h3;
      icf = 2'b00;
      step(2);
      sk2 = 1'b1;
      step(1);
      check({skn, f2, ir2}, 8'h04);
      step(1);
      sk2 = 1'b0;
      check(skn, 1'b0);
      // Edge modes: falling, rising, both
      tps = 4'h0;
      tc1 = 4'h1;
      for (int m = 0; m < 3; m++) begin
         ext_level = (m == 1);
         step(6);
         ext = (m == 0) ? 3'b001 : (m == 1) ? 3'b101 : 3'b011;
         step(2);
         ext_level = ~ext_level;
         step(6);
         check(latch, m == 2);
         ext_level = ~ext_level;
         step(6);
         check(latch, 1'b1);
         ext = 3'b000;
         step(2);
         check(latch, 1'b0);
      end
      // Auto-stop on first underflow; loads only while stopped
      ldata = 8'h02;
      ld1 = 1'b1;
      tc2 = 4'h4;
      step(1);
      ld1 = 1'b0;
      ldata = 8'h03;
      wr1 = 1'b1;
      ext_level = 1'b1;
      step(1);
      wr1 = 1'b0;
      step(5);
      ext = 3'b001;
      tc1 = 4'hF;
      tc2 = 4'hC;
      tps = 4'h1;
      icf = 2'b01;
      step(2);
      ext_level = 1'b0;
      wait_for(latch, 1'b1, 10);
      wait_for(latch, 1'b0, 60);
      exp_c = (exp_c == 0) ? n : exp_c - 1;
      step(1);
      check({f1, latch, ir1, pout}, 8'h0B);
      check(c2, exp_c[7:0]);
      step(8);
      check(c1, 8'h03);
      sk1 = 1'b1;
      step(1);
      sk1 = 1'b0;
      check({skn, f1}, 8'h02);
      // Second sync start, then clear by interrupt taken
      ext_level = 1'b1;
      step(6);
      ext_level = 1'b0;
      wait_for(latch, 1'b1, 10);
      wait_for(latch, 1'b0, 80);
      step(1);
      check({f1, ir1}, 8'h03);
      it1 = 1'b1;
      step(1);
      it1 = 1'b0;
      check({f1, ir1, skn}, 8'h00);
      // Falling pin edges as the second source
      tc1 = 4'h0;
      tc2 = 4'h0;
      ext = 3'h0;
      icf = 2'b10;
      ldata = 8'h05;
      ld2 = 1'b1;
      step(1);
      ld2 = 1'b0;
      tc2 = 4'hA;
      step(2);
      for (k = 1; k <= 6; k++) begin
         io_pulse = 1'b1;
         step(1);
         io_pulse = 1'b0;
         step(8);
         check(c2, (k == 6) ? 8'h05 : 8'(5 - k));
      end
      check({f2, ir2}, 8'h03);
      it2 = 1'b1;
      step(1);
      it2 = 1'b0;
      check({f2, ir2}, 8'h00);
      end_of_test();
   end
endmodule : testbench

// File: verilog/drt_count_if.sv
// Count pulse and load signals between the block top and one down-counter
`timescale 1ns/1ps
interface drt_count_if;
   logic       tick;
   logic       load;
   logic [7:0] load_value;
   logic [7:0] reload_value;
   logic [7:0] count;
   logic       underflow;
   modport ctrl (output tick, output load, output load_value, output reload_value,
                 input count, input underflow);
   modport counter (input tick, input load, input load_value, input reload_value,
                    output count, output underflow);
endinterface : drt_count_if

// File: verilog/drt_down_counter.sv
// Eight-bit reload down-counter with underflow pulse
`timescale 1ns/1ps
module drt_down_counter (
   input  wire logic   core_clk,
   input  wire logic   reset,
   drt_count_if.counter port_c
);
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] reload;
      logic       underflow;
   } drt_cnt_state_type;

   drt_cnt_state_type state;
   drt_cnt_state_type next_state;

   always_comb begin
      next_state = state;
      next_state.underflow = 1'b0;
      if (port_c.load) begin
         next_state.count  = port_c.load_value;
         next_state.reload = port_c.load_value;
      end else begin
         next_state.reload = port_c.reload_value;
         if (port_c.tick) begin
            if (state.count == 8'h00) begin
               // Reload then continue; n loaded divides by n+1
               next_state.count     = port_c.reload_value;
               next_state.underflow = 1'b1;
            end else begin
               next_state.count = state.count - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign port_c.count     = state.count;
   assign port_c.underflow = state.underflow;
endmodule : drt_down_counter

// File: verilog/drt_pkg.sv
// Constants and types shared by the dual reload timer block
package drt_pkg;
   localparam int TIMER_WIDTH = 8;
   // First timer control field positions
   localparam int FIRST_SYNC_BIT    = 0;
   localparam int FIRST_RUN_BIT     = 1;
   localparam int PRESCALE_DIV_BIT  = 2;
   localparam int PRESCALE_RUN_BIT  = 3;
   // Second timer control field positions
   localparam int SECOND_SRC_LO_BIT = 0;
   localparam int SECOND_SRC_HI_BIT = 1;
   localparam int AUTO_STOP_BIT     = 2;
   localparam int SECOND_RUN_BIT    = 3;
   // Pin select field positions
   localparam int PIN_FUNC_BIT      = 0;
   localparam int PIN_OUT_SEL_BIT   = 1;
   // External pin control field positions
   localparam int EXT_ENABLE_BIT    = 0;
   localparam int EXT_MODE_BIT      = 1;
   localparam int EXT_POL_BIT       = 2;
   // Interrupt control: flag routes to interrupt when set
   localparam int INT_FIRST_BIT     = 0;
   localparam int INT_SECOND_BIT    = 1;
   // Prescaler divide terminal counts
   localparam logic [3:0] PRESCALE_LAST_SHORT = 4'h3;
   localparam logic [3:0] PRESCALE_LAST_LONG  = 4'hF;
   localparam logic [3:0] CTRL_RESET          = 4'h0;
   typedef enum logic [1:0] {
      DRT_SRC_FIRST_UNDER = 2'h0,
      DRT_SRC_PRESCALE    = 2'h1,
      DRT_SRC_PIN         = 2'h2,
      DRT_SRC_SYSTEM      = 2'h3
   } drt_src_type;
endpackage : drt_pkg

// File: verilog/drt_timer_top.sv
// Dual reload timers with prescaler, synchronous start and counter pin
`timescale 1ns/1ps
module drt_timer_top (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [3:0] timer_control_first,
   input  wire logic [3:0] timer_control_second,
   input  wire logic [3:0] timer_control_pin_select,
   input  wire logic [2:0] ext_pin_control,
   input  wire logic [1:0] interrupt_control_first,
   input  wire logic       load_first_timer_instr,
   input  wire logic       load_second_timer_instr,
   input  wire logic       write_first_reload_instr,
   input  wire logic [7:0] load_data,
   input  wire logic       skip_on_first_flag_instr,
   input  wire logic       skip_on_second_flag_instr,
   input  wire logic       first_int_taken,
   input  wire logic       second_int_taken,
   input  wire logic       ext_int_pin,
   input  wire logic       timer_io_pin_in,
   output logic [7:0]      first_count,
   output logic [7:0]      second_count,
   output logic            first_timer_underflow_flag,
   output logic            second_timer_underflow_flag,
   output logic            first_int_request,
   output logic            second_int_request,
   output logic            skip_next,
   output logic            sync_start_latched,
   output logic            timer_io_pin_out,
   output logic            timer_io_pin_oe_n
);
   typedef struct packed {
      logic [1:0] ext_sync;
      logic [1:0] io_sync;
      logic       ext_prev;
      logic       io_prev;
      logic [3:0] prescale;
      logic       sync_latch;
      logic [7:0] first_reload;
      logic [7:0] second_reload;
      logic       flag_first;
      logic       flag_second;
      logic       skip;
      logic       toggle_first;
      logic       toggle_second;
      logic       pin_out;
      logic       pin_oe_n;
      logic       int_first;
      logic       int_second;
      logic [7:0] first_count;
      logic [7:0] second_count;
   } drt_state_type;

   drt_state_type state;
   drt_state_type next_state;
   logic          prescale_tick;
   logic          ext_edge;
   logic          first_gate;
   logic          first_under;
   logic          second_under;
   drt_pkg::drt_src_type second_src;

   drt_count_if first_if ();
   drt_count_if second_if ();

   drt_down_counter u_first (
      .core_clk (core_clk),
      .reset    (reset),
      .port_c   (first_if)
   );

   drt_down_counter u_second (
      .core_clk (core_clk),
      .reset    (reset),
      .port_c   (second_if)
   );

   assign first_under  = first_if.underflow;
   assign second_under = second_if.underflow;
   assign second_src   = drt_pkg::drt_src_type'(
      timer_control_second[drt_pkg::SECOND_SRC_HI_BIT:drt_pkg::SECOND_SRC_LO_BIT]);

   always_comb begin
      logic pin_level;
      logic pin_fall;
      logic sync_on;
      logic rise;
      logic fall;
      pin_level  = state.ext_sync[1];
      rise       = pin_level & ~state.ext_prev;
      fall       = ~pin_level & state.ext_prev;
      pin_fall   = ~state.io_sync[1] & state.io_prev;
      sync_on    = timer_control_first[drt_pkg::FIRST_SYNC_BIT];
      next_state = state;
      // Second stage alone feeds edge logic to avoid metastable reads
      next_state.ext_sync = {state.ext_sync[0], ext_int_pin};
      next_state.io_sync  = {state.io_sync[0], timer_io_pin_in};
      next_state.ext_prev = state.ext_sync[1];
      next_state.io_prev  = state.io_sync[1];
      // Prescaler: cleared while stopped
      prescale_tick = 1'b0;
      if (!timer_control_first[drt_pkg::PRESCALE_RUN_BIT]) begin
         next_state.prescale = 4'h0;
      end else if (state.prescale == (timer_control_first[drt_pkg::PRESCALE_DIV_BIT] ?
                   drt_pkg::PRESCALE_LAST_LONG : drt_pkg::PRESCALE_LAST_SHORT)) begin
         next_state.prescale = 4'h0;
         prescale_tick = 1'b1;
      end else begin
         next_state.prescale = state.prescale + 4'h1;
      end
      // Start latch edge selection
      if (ext_pin_control[drt_pkg::EXT_MODE_BIT]) begin
         ext_edge = rise | fall;
      end else begin
         ext_edge = ext_pin_control[drt_pkg::EXT_POL_BIT] ? rise : fall;
      end
      if (!ext_pin_control[drt_pkg::EXT_ENABLE_BIT]) begin
         next_state.sync_latch = 1'b0;
      end else if (sync_on && timer_control_second[drt_pkg::AUTO_STOP_BIT]
                   && state.sync_latch && first_under) begin
         next_state.sync_latch = 1'b0;
      end else if (sync_on && ext_edge) begin
         next_state.sync_latch = 1'b1;
      end
      first_gate = timer_control_first[drt_pkg::FIRST_RUN_BIT]
                   & (~sync_on | state.sync_latch);
      first_if.tick = first_gate & prescale_tick;
      first_if.load = load_first_timer_instr;
      first_if.load_value = load_data;
      if (write_first_reload_instr) begin
         next_state.first_reload = load_data;
      end else if (load_first_timer_instr) begin
         next_state.first_reload = load_data;
      end
      first_if.reload_value = state.first_reload;
      case (second_src)
         drt_pkg::DRT_SRC_FIRST_UNDER: second_if.tick = first_under;
         drt_pkg::DRT_SRC_PRESCALE:    second_if.tick = prescale_tick;
         drt_pkg::DRT_SRC_PIN:         second_if.tick = pin_fall;
         drt_pkg::DRT_SRC_SYSTEM:      second_if.tick = 1'b1;
         default:                      second_if.tick = 1'b0;
      endcase
      // Second timer also waits on the start latch in sync mode
      second_if.tick = second_if.tick & timer_control_second[drt_pkg::SECOND_RUN_BIT]
                       & (~sync_on | state.sync_latch);
      second_if.load = load_second_timer_instr;
      second_if.load_value = load_data;
      if (load_second_timer_instr) begin
         next_state.second_reload = load_data;
      end
      second_if.reload_value = state.second_reload;
      // Flags: underflow set wins over any clear
      next_state.skip = 1'b0;
      if (skip_on_first_flag_instr && state.flag_first) begin
         next_state.skip = 1'b1;
      end
      if (skip_on_second_flag_instr && state.flag_second) begin
         next_state.skip = 1'b1;
      end
      if ((skip_on_first_flag_instr && state.flag_first) || first_int_taken) begin
         next_state.flag_first = 1'b0;
      end
      if ((skip_on_second_flag_instr && state.flag_second) || second_int_taken) begin
         next_state.flag_second = 1'b0;
      end
      if (first_under) begin
         next_state.flag_first = 1'b1;
      end
      if (second_under) begin
         next_state.flag_second = 1'b1;
      end
      next_state.int_first  = next_state.flag_first
                              & interrupt_control_first[drt_pkg::INT_FIRST_BIT];
      next_state.int_second = next_state.flag_second
                              & interrupt_control_first[drt_pkg::INT_SECOND_BIT];
      // Half-rate output toggles
      if (first_under) begin
         next_state.toggle_first = ~state.toggle_first;
      end
      if (second_under) begin
         next_state.toggle_second = ~state.toggle_second;
      end
      next_state.pin_out = timer_control_pin_select[drt_pkg::PIN_OUT_SEL_BIT] ?
                           next_state.toggle_second : next_state.toggle_first;
      next_state.pin_oe_n = ~timer_control_pin_select[drt_pkg::PIN_FUNC_BIT];
      next_state.first_count  = first_if.count;
      next_state.second_count = second_if.count;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
         state.pin_oe_n <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign first_count                 = state.first_count;
   assign second_count                = state.second_count;
   assign first_timer_underflow_flag  = state.flag_first;
   assign second_timer_underflow_flag = state.flag_second;
   assign first_int_request           = state.int_first;
   assign second_int_request          = state.int_second;
   assign skip_next                   = state.skip;
   assign sync_start_latched          = state.sync_latch;
   assign timer_io_pin_out            = state.pin_out;
   assign timer_io_pin_oe_n           = state.pin_oe_n;
endmodule : drt_timer_top
